// [design/fdsi_pkg.sv]
// Purpose: Shared types and constants for the floppy drive signal interface.
// Assumes: One 125 MHz clock; all drive pins except the two density outputs are active low.
// Notes:   Times are kept in ns and turned into cycle counts here.
package fdsi_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 8;
  localparam int STEP_SETUP_NS  = 1000;
  localparam int STEP_WIDTH_NS  = 1000;
  localparam int STEP_HOLD_NS   = 1000;
  localparam int GATE_LEAD_NS   = 1000;
  localparam int FLUX_WIDTH_NS  = 120;
  localparam int RESET_MIN_NS   = 500;

  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE  = 8'h01;
  localparam logic [CNT_W-1:0] STEP_SETUP_CYC =
    CNT_W'((STEP_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] STEP_WIDTH_CYC =
    CNT_W'((STEP_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] STEP_HOLD_CYC =
    CNT_W'((STEP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] GATE_LEAD_CYC =
    CNT_W'((GATE_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] FLUX_WIDTH_CYC =
    CNT_W'((FLUX_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Digital input byte
  // ----------------------------------------------------------------
  localparam logic [15:0] DIG_IN_ADDR    = 16'h03f7;
  localparam int          DIG_IN_CHG_BIT = 7;
  localparam logic [7:0]  DIG_IN_RESET   = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SETUP = 2'b01,
    ST_PULSE = 2'b10,
    ST_HOLD  = 2'b11
  } fdsi_step_e;

  typedef enum logic [1:0] {
    WR_IDLE   = 2'b00,
    WR_LEAD   = 2'b01,
    WR_ACTIVE = 2'b10
  } fdsi_wr_e;

  typedef struct packed {
    logic       step_req;
    logic       step_outward;
    logic       side_one;
    logic       write_req;
    logic       flux_pulse;
    logic       drive_sel_en;
    logic       drive_num;
    logic [1:0] motor_on;
  } fdsi_cmd_s;

  typedef struct packed {
    logic read_flux_n;
    logic index_hole_n;
    logic at_outer_track_n;
    logic write_protected_n;
    logic media_changed_n;
  } fdsi_drv_s;

  typedef struct packed {
    logic       side_select_n;
    logic       seek_direction_n;
    logic       step_pulse_n;
    logic       write_gate_n;
    logic       write_flux_n;
    logic [1:0] drive_select_n;
    logic [1:0] spindle_on_n;
    logic       density_out_zero;
    logic       density_out_one;
  } fdsi_pins_s;

  typedef struct packed {
    logic       step_busy;
    logic       step_done;
    logic       write_active;
    logic       write_refused;
    logic       read_flux_edge;
    logic       index_edge;
    logic       at_outer_track;
    logic       write_protected;
    logic [7:0] digital_input;
  } fdsi_stat_s;

  localparam fdsi_pins_s PINS_RELEASED = 11'h7ff;
  localparam fdsi_drv_s  DRV_IDLE      = 5'h1f;
  localparam fdsi_stat_s STAT_RESET    = 16'h0000;

endpackage : fdsi_pkg

// [design/fdsi_floppy_if.sv]
// Purpose: Pin-level interface from the disk controller core to two floppy drives.
// Assumes: Drive inputs are asynchronous; core commands are on this clock.
// Notes:   Open-drain pins leave the wire level to the board pull-ups.
`timescale 1ns/1ps

module fdsi_floppy_if (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 resetn,
  // Controller core
  input  wire fdsi_pkg::fdsi_cmd_s  cmd,
  output fdsi_pkg::fdsi_stat_s      status,
  // Configuration
  input  wire logic                 cfg_load,
  input  wire logic                 cfg_drive,
  input  wire logic [1:0]           cfg_density,
  // Drive cable
  input  wire fdsi_pkg::fdsi_drv_s  drive_in,
  output fdsi_pkg::fdsi_pins_s      pin_out,
  output fdsi_pkg::fdsi_pins_s      pin_oe_n
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  fdsi_pkg::fdsi_drv_s sync1_q;
  fdsi_pkg::fdsi_drv_s sync2_q;
  fdsi_pkg::fdsi_drv_s sync3_q;
  logic                protect;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= fdsi_pkg::DRV_IDLE;
      sync2_q <= fdsi_pkg::DRV_IDLE;
      sync3_q <= fdsi_pkg::DRV_IDLE;
    end else begin
      sync1_q <= drive_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  assign protect = !sync2_q.write_protected_n;

  // ----------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------
  // No reset here on purpose: a chip reset must not lose the setup.
  logic [1:0] cfg_q [2];
  logic [1:0] cfg_d [2];

  always_comb begin
    cfg_d = cfg_q;
    if (cfg_load) begin
      cfg_d[cfg_drive] = cfg_density;
    end
  end

  always_ff @(posedge clock) begin
    cfg_q <= cfg_d;
  end

  // ----------------------------------------------------------------
  // Step sequencer
  // ----------------------------------------------------------------
  fdsi_pkg::fdsi_step_e         step_st_q;
  fdsi_pkg::fdsi_step_e         step_st_d;
  logic [fdsi_pkg::CNT_W-1:0]   step_cnt_q;
  logic [fdsi_pkg::CNT_W-1:0]   step_cnt_d;
  logic                         dir_q;
  logic                         dir_d;
  logic                         step_done_d;

  always_comb begin
    step_st_d   = step_st_q;
    step_cnt_d  = step_cnt_q;
    dir_d       = dir_q;
    step_done_d = 1'b0;
    case (step_st_q)
      fdsi_pkg::ST_IDLE: begin
        if (cmd.step_req) begin
          step_st_d  = fdsi_pkg::ST_SETUP;
          step_cnt_d = fdsi_pkg::STEP_SETUP_CYC;
          dir_d      = cmd.step_outward;
        end
      end
      fdsi_pkg::ST_SETUP: begin
        if (step_cnt_q == fdsi_pkg::CNT_ONE) begin
          step_st_d  = fdsi_pkg::ST_PULSE;
          step_cnt_d = fdsi_pkg::STEP_WIDTH_CYC;
        end else begin
          step_cnt_d = step_cnt_q - fdsi_pkg::CNT_ONE;
        end
      end
      fdsi_pkg::ST_PULSE: begin
        if (step_cnt_q == fdsi_pkg::CNT_ONE) begin
          step_st_d  = fdsi_pkg::ST_HOLD;
          step_cnt_d = fdsi_pkg::STEP_HOLD_CYC;
        end else begin
          step_cnt_d = step_cnt_q - fdsi_pkg::CNT_ONE;
        end
      end
      fdsi_pkg::ST_HOLD: begin
        if (step_cnt_q == fdsi_pkg::CNT_ONE) begin
          step_st_d   = fdsi_pkg::ST_IDLE;
          step_done_d = 1'b1;
        end else begin
          step_cnt_d = step_cnt_q - fdsi_pkg::CNT_ONE;
        end
      end
      default: begin
        step_st_d = fdsi_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      step_st_q  <= fdsi_pkg::ST_IDLE;
      step_cnt_q <= fdsi_pkg::CNT_ZERO;
      dir_q      <= 1'b0;
    end else begin
      step_st_q  <= step_st_d;
      step_cnt_q <= step_cnt_d;
      dir_q      <= dir_d;
    end
  end

  // ----------------------------------------------------------------
  // Write sequencer
  // ----------------------------------------------------------------
  // A refused write must be requested again; a held request never retries.
  fdsi_pkg::fdsi_wr_e           wr_st_q;
  fdsi_pkg::fdsi_wr_e           wr_st_d;
  logic [fdsi_pkg::CNT_W-1:0]   wr_cnt_q;
  logic [fdsi_pkg::CNT_W-1:0]   wr_cnt_d;
  logic [fdsi_pkg::CNT_W-1:0]   flux_cnt_q;
  logic [fdsi_pkg::CNT_W-1:0]   flux_cnt_d;
  logic                         wr_req_q;
  logic                         refused_d;

  always_comb begin
    wr_st_d    = wr_st_q;
    wr_cnt_d   = wr_cnt_q;
    refused_d  = 1'b0;
    flux_cnt_d = (flux_cnt_q != fdsi_pkg::CNT_ZERO) ? flux_cnt_q - fdsi_pkg::CNT_ONE : fdsi_pkg::CNT_ZERO;
    case (wr_st_q)
      fdsi_pkg::WR_IDLE: begin
        if (cmd.write_req && !wr_req_q) begin
          if (protect) begin
            refused_d = 1'b1;
          end else begin
            wr_st_d    = fdsi_pkg::WR_LEAD;
            wr_cnt_d   = fdsi_pkg::GATE_LEAD_CYC;
            flux_cnt_d = fdsi_pkg::CNT_ZERO;
          end
        end
      end
      fdsi_pkg::WR_LEAD: begin
        if (!cmd.write_req || protect) begin
          wr_st_d   = fdsi_pkg::WR_IDLE;
          refused_d = protect;
        end else if (wr_cnt_q == fdsi_pkg::CNT_ONE) begin
          wr_st_d = fdsi_pkg::WR_ACTIVE;
        end else begin
          wr_cnt_d = wr_cnt_q - fdsi_pkg::CNT_ONE;
        end
      end
      fdsi_pkg::WR_ACTIVE: begin
        if (!cmd.write_req || protect) begin
          wr_st_d   = fdsi_pkg::WR_IDLE;
          refused_d = protect;
        end else if (cmd.flux_pulse) begin
          flux_cnt_d = fdsi_pkg::FLUX_WIDTH_CYC;
        end
      end
      default: begin
        wr_st_d = fdsi_pkg::WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_st_q    <= fdsi_pkg::WR_IDLE;
      wr_cnt_q   <= fdsi_pkg::CNT_ZERO;
      flux_cnt_q <= fdsi_pkg::CNT_ZERO;
      wr_req_q   <= 1'b0;
    end else begin
      wr_st_q    <= wr_st_d;
      wr_cnt_q   <= wr_cnt_d;
      flux_cnt_q <= flux_cnt_d;
      wr_req_q   <= cmd.write_req;
    end
  end

  // ----------------------------------------------------------------
  // Pins and status
  // ----------------------------------------------------------------
  fdsi_pkg::fdsi_pins_s pins_q;
  fdsi_pkg::fdsi_pins_s pins_d;
  fdsi_pkg::fdsi_stat_s stat_q;
  fdsi_pkg::fdsi_stat_s stat_d;

  always_comb begin
    pins_d.side_select_n    = !cmd.side_one;
    pins_d.seek_direction_n = dir_d;
    pins_d.step_pulse_n     = (step_st_d != fdsi_pkg::ST_PULSE);
    pins_d.write_gate_n     = (wr_st_d == fdsi_pkg::WR_IDLE);
    pins_d.write_flux_n     = (flux_cnt_d == fdsi_pkg::CNT_ZERO);
    for (int i = 0; i < 2; i++) begin
      pins_d.drive_select_n[i] = !(cmd.drive_sel_en && (cmd.drive_num == 1'(i)));
    end
    pins_d.spindle_on_n     = ~cmd.motor_on;
    pins_d.density_out_zero = cfg_q[cmd.drive_num][0];
    pins_d.density_out_one  = cfg_q[cmd.drive_num][1];
    stat_d                  = fdsi_pkg::STAT_RESET;
    stat_d.step_busy        = (step_st_d != fdsi_pkg::ST_IDLE);
    stat_d.step_done        = step_done_d;
    stat_d.write_active     = (wr_st_d == fdsi_pkg::WR_ACTIVE);
    stat_d.write_refused    = refused_d;
    stat_d.read_flux_edge   = sync3_q.read_flux_n && !sync2_q.read_flux_n;
    stat_d.index_edge       = sync3_q.index_hole_n && !sync2_q.index_hole_n;
    stat_d.at_outer_track   = !sync2_q.at_outer_track_n;
    stat_d.write_protected  = protect;
    stat_d.digital_input[fdsi_pkg::DIG_IN_CHG_BIT] = !sync2_q.media_changed_n;
  end

  // Data and enable are one flop pair so the pin never glitches between them.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pins_q   <= fdsi_pkg::PINS_RELEASED;
      pin_oe_n <= fdsi_pkg::PINS_RELEASED;
      stat_q   <= fdsi_pkg::STAT_RESET;
    end else begin
      pins_q   <= pins_d;
      pin_oe_n <= pins_d;
      stat_q   <= stat_d;
    end
  end

  assign pin_out = pins_q;
  assign status  = stat_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [fdsi_pkg::CNT_W-1:0] low_cnt_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      low_cnt_q <= fdsi_pkg::CNT_ZERO;
    end else if (!pins_q.step_pulse_n) begin
      low_cnt_q <= low_cnt_q + fdsi_pkg::CNT_ONE;
    end else begin
      low_cnt_q <= fdsi_pkg::CNT_ZERO;
    end
  end

  // Checks arm one edge after reset release. At the release edge itself the flops still see reset.
  logic chk_arm_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      chk_arm_q <= 1'b0;
    end else begin
      chk_arm_q <= 1'b1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn || !chk_arm_q);

  side_select_a: assert property (1'b1 |=> pins_q.side_select_n == !$past(cmd.side_one))
    else $error("side select level wrong");
  step_dir_a: assert property (cmd.step_req && step_st_q == fdsi_pkg::ST_IDLE |=>
    pins_q.seek_direction_n == $past(cmd.step_outward))
    else $error("seek direction not taken from step request");
  step_width_a: assert property ($rose(pins_q.step_pulse_n) |-> low_cnt_q == fdsi_pkg::STEP_WIDTH_CYC)
    else $error("step pulse width wrong");
  step_idle_a: assert property (step_st_q == fdsi_pkg::ST_IDLE && !cmd.step_req |=> pins_q.step_pulse_n)
    else $error("step pulse without request");
  dir_stable_a: assert property (!pins_q.step_pulse_n |-> $stable(pins_q.seek_direction_n))
    else $error("seek direction moved during step");
  gate_lead_a: assert property ($fell(pins_q.write_gate_n) |-> pins_q.write_flux_n [*8])
    else $error("write data inside gate lead time");
  flux_pulse_a: assert property (cmd.flux_pulse && cmd.write_req && !protect &&
    wr_st_q == fdsi_pkg::WR_ACTIVE |=> !pins_q.write_flux_n [*8])
    else $error("write flux pulse missing");
  protect_block_a: assert property (protect && wr_st_q == fdsi_pkg::WR_IDLE |=> pins_q.write_gate_n)
    else $error("write gate asserted while protected");
  read_edge_a: assert property ($fell(sync2_q.read_flux_n) |=> stat_q.read_flux_edge)
    else $error("read flux edge lost");
  media_bit_a: assert property (1'b1 |=>
    stat_q.digital_input[fdsi_pkg::DIG_IN_CHG_BIT] == !$past(sync2_q.media_changed_n))
    else $error("media change bit wrong");
  drive_select_a: assert property (1'b1 |=> pins_q.drive_select_n[1] ==
    !($past(cmd.drive_sel_en) && $past(cmd.drive_num)))
    else $error("drive select wrong");
  motor_on_a: assert property (1'b1 |=> pins_q.spindle_on_n == ~$past(cmd.motor_on))
    else $error("motor enable wrong");
  density_out_a: assert property (1'b1 |=>
    {pins_q.density_out_one, pins_q.density_out_zero} == $past(cfg_q[cmd.drive_num]))
    else $error("density pins wrong");

  step_done_c: cover property (stat_q.step_done);
  write_flux_c: cover property (stat_q.write_active ##1 !pins_q.write_flux_n);
  refused_c: cover property (stat_q.write_refused);

endmodule : fdsi_floppy_if

// [tb/fdsi_drive_model.sv]
// Purpose: Behavioural model of one floppy drive mechanism on the cable.
// Assumes: Step and direction come in as wire levels; outputs idle high.
// Notes:   The media change flag clears on a step, as real drives do.
`timescale 1ns/1ps
module fdsi_drive_model #(
  parameter int START_TRACK = 1
) (
  // Cable from the controller
  input  wire logic          step_wire,
  input  wire logic          dir_wire,
  // Scenario controls
  input  wire logic          write_protect,
  input  wire logic          door_open,
  // Cable to the controller
  output fdsi_pkg::fdsi_drv_s drive_in
);
  int   track   = START_TRACK;
  logic changed = 1'b0;
  logic flux_n  = 1'b1;
  logic index_n = 1'b1;

  // ------------------------------------------------------------
  // Head and media state
  // ------------------------------------------------------------
  always @(negedge step_wire) begin
    track = dir_wire ? ((track > 0) ? track - 1 : 0) : track + 1;
    changed = 1'b0;
  end
  always @(posedge door_open) begin
    changed = 1'b1;
  end

  // Pulses are timed off the controller clock on purpose, so edges land mid-cycle.
  task send_flux(input int n);
    repeat (n) begin
      #43 flux_n = 1'b0;
      #50 flux_n = 1'b1;
    end
  endtask : send_flux

  task send_index;
    #37 index_n = 1'b0;
    #200 index_n = 1'b1;
  endtask : send_index

  assign drive_in = {flux_n, index_n, (track != 0), ~write_protect, ~(door_open | changed)};
endmodule : fdsi_drive_model

// [tb/fdsi_floppy_if_tb_top.sv]
// Purpose: Self-checking bench for the floppy drive signal interface.
// Assumes: One drive model on the cable; open-drain pins pulled high.
// Notes:   Pin counters sample the wire before each clock edge updates it.
`timescale 1ns/1ps
module fdsi_floppy_if_tb_top;
  typedef struct packed {
    logic       side;
    logic       en;
    logic       num;
    logic [1:0] mtr;
    logic [6:0] exp;
  } fdsi_row_s;

  logic                 clock = 1'b0;
  logic                 resetn = 1'b0;
  fdsi_pkg::fdsi_cmd_s  cmd = '0;
  logic                 cfg_load = 1'b1;
  logic                 cfg_drive = 1'b0;
  logic [1:0]           cfg_density = 2'h1;
  logic                 write_protect = 1'b0;
  logic                 door_open = 1'b0;
  fdsi_pkg::fdsi_stat_s status;
  fdsi_pkg::fdsi_drv_s  drive_in;
  fdsi_pkg::fdsi_pins_s pin_out, pin_oe_n, pin_wire, wire_q;
  int mismatches = 0, compares = 0;
  int step_falls = 0, step_low = 0, wf_falls = 0, wf_low = 0, gate_low = 0;
  int rd_edges = 0, idx_edges = 0, refusals = 0;
  int s0, s1, n;
  fdsi_row_s rows [4] = '{'{1'b1, 1'b1, 1'b0, 2'h1, 7'h2a}, '{1'b0, 1'b1, 1'b1, 2'h2, 7'h55},
                          '{1'b0, 1'b0, 1'b1, 2'h3, 7'h71}, '{1'b1, 1'b0, 1'b0, 2'h0, 7'h3e}};

  always #4 clock = ~clock;

  fdsi_floppy_if dut_u (.clock(clock), .resetn(resetn), .cmd(cmd), .status(status), .cfg_load(cfg_load),
    .cfg_drive(cfg_drive), .cfg_density(cfg_density), .drive_in(drive_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n));
  fdsi_drive_model dm_u (.step_wire(pin_wire.step_pulse_n), .dir_wire(pin_wire.seek_direction_n),
    .write_protect(write_protect), .door_open(door_open), .drive_in(drive_in));

  // Open drain: a line is low only where the enable and the level are both low; pull-ups do the rest.
  assign pin_wire = pin_out | pin_oe_n;

  // ------------------------------------------------------------
  // Pin and status counters
  // ------------------------------------------------------------
  always @(posedge clock) begin
    wire_q <= pin_wire;
    if (wire_q.step_pulse_n === 1'b1 && pin_wire.step_pulse_n === 1'b0) step_falls++;
    if (wire_q.write_flux_n === 1'b1 && pin_wire.write_flux_n === 1'b0) wf_falls++;
    if (pin_wire.step_pulse_n === 1'b0) step_low++;
    if (pin_wire.write_flux_n === 1'b0) wf_low++;
    if (pin_wire.write_gate_n === 1'b0) gate_low++;
    if (status.read_flux_edge === 1'b1) rd_edges++;
    if (status.index_edge === 1'b1) idx_edges++;
    if (status.write_refused === 1'b1) refusals++;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task conclude;
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  task cyc(input int k);
    repeat (k) @(posedge clock);
    @(negedge clock);
  endtask : cyc

  task settle;
    @(negedge clock);
    @(negedge clock);
  endtask : settle

  task do_step(input logic outward);
    s0 = step_falls;
    s1 = step_low;
    @(posedge clock) begin cmd.step_req <= 1'b1; cmd.step_outward <= outward; end
    @(posedge clock) cmd.step_req <= 1'b0;
    settle();
    check("seek_direction", pin_wire.seek_direction_n, outward);
    check("step_busy", status.step_busy, 1);
    // A second request and a flipped direction while busy must change nothing.
    @(posedge clock) begin cmd.step_req <= 1'b1; cmd.step_outward <= ~outward; end
    @(posedge clock) cmd.step_req <= 1'b0;
    n = 0;
    while (status.step_done !== 1'b1 && n < 600) begin @(negedge clock); n++; end
    cyc(2);
    check("step_done_wait", n < 600, 1);
    check("step_falls", step_falls - s0, 1);
    check("step_width", step_low - s1, 125);
    check("direction_held", pin_wire.seek_direction_n, outward);
    cyc(6);
  endtask : do_step

  task flux_once;
    @(posedge clock) cmd.flux_pulse <= 1'b1;
    @(posedge clock) cmd.flux_pulse <= 1'b0;
    cyc(20);
  endtask : flux_once

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    // Configuration has no reset value, so both drives are loaded while reset holds.
    @(posedge clock) begin cfg_drive <= 1'b1; cfg_density <= 2'h2; end
    @(posedge clock) cfg_load <= 1'b0;
    cyc(2);
    check("reset_pins", pin_wire, fdsi_pkg::PINS_RELEASED);
    check("reset_status", status, fdsi_pkg::STAT_RESET);
    @(posedge clock) resetn <= 1'b1;
    foreach (rows[i]) begin
      @(posedge clock) begin
        cmd.side_one <= rows[i].side; cmd.drive_sel_en <= rows[i].en;
        cmd.drive_num <= rows[i].num; cmd.motor_on <= rows[i].mtr;
      end
      settle();
      check("pin_levels", {pin_wire.side_select_n, pin_wire.drive_select_n, pin_wire.spindle_on_n,
        pin_wire.density_out_zero, pin_wire.density_out_one}, rows[i].exp);
    end
    @(posedge clock) begin door_open <= 1'b1; cmd.drive_sel_en <= 1'b1; end
    cyc(6);
    check("media_changed", status.digital_input, 8'h80);
    @(posedge clock) door_open <= 1'b0;
    cyc(6);
    check("media_latched", status.digital_input, 8'h80);
    do_step(1'b1);
    check("outer_track", status.at_outer_track, 1);
    check("media_cleared", status.digital_input, 8'h00);
    do_step(1'b0);
    check("inner_track", status.at_outer_track, 0);
    s0 = rd_edges;
    dm_u.send_flux(3);
    cyc(8);
    check("read_edges", rd_edges - s0, 3);
    s0 = idx_edges;
    dm_u.send_index();
    cyc(8);
    check("index_edges", idx_edges - s0, 1);
    s0 = wf_falls;
    flux_once();
    check("idle_flux", wf_falls - s0, 0);
    @(posedge clock) cmd.write_req <= 1'b1;
    n = 0;
    while (pin_wire.write_gate_n !== 1'b0 && n < 4) begin @(negedge clock); n++; end
    check("gate_prompt", n < 4, 1);
    n = 0;
    while (status.write_active !== 1'b1 && n < 300) begin @(negedge clock); n++; end
    check("gate_lead", n, 125);
    s0 = wf_falls;
    s1 = wf_low;
    flux_once();
    flux_once();
    check("flux_falls", wf_falls - s0, 2);
    check("flux_width", wf_low - s1, 30);
    @(posedge clock) cmd.write_req <= 1'b0;
    settle();
    check("gate_release", pin_wire.write_gate_n, 1);
    @(posedge clock) write_protect <= 1'b1;
    cyc(6);
    check("write_protected", status.write_protected, 1);
    s0 = refusals;
    s1 = gate_low;
    @(posedge clock) cmd.write_req <= 1'b1;
    cyc(10);
    check("protect_refused", refusals - s0, 1);
    check("protect_no_gate", gate_low - s1, 0);
    @(posedge clock) begin cmd.write_req <= 1'b0; write_protect <= 1'b0; end
    cyc(6);
    @(posedge clock) cmd.write_req <= 1'b1;
    cyc(20);
    s0 = refusals;
    @(posedge clock) write_protect <= 1'b1;
    cyc(8);
    check("protect_abort", refusals - s0, 1);
    check("abort_gate", pin_wire.write_gate_n, 1);
    @(posedge clock) begin cmd.write_req <= 1'b0; write_protect <= 1'b0; end
    @(posedge clock) resetn <= 1'b0;
    cyc(63);
    @(posedge clock) resetn <= 1'b1;
    settle();
    check("cfg_kept", {pin_wire.density_out_zero, pin_wire.density_out_one}, 2'h2);
    conclude();
  end

  initial begin
    cyc(20000);
    mismatches++;
    conclude();
  end
endmodule : fdsi_floppy_if_tb_top
